// ---- design/pcmsp_pkg.sv ----
// Operation
// - power-up begins in short frame mode
// - short frame: next rising edge drives sign
// - seven more bits, release on next fall
// - short receive: capture eight following falling edges
// - synchronous mode receives on transmit bit clock
// - frame mode judged from transmit pulse only
// - long frame: drive at later of edges
// - long frame: release at later of two
// - long receive: capture eight falls after rise
// - both frame formats in both clock modes
// - each transmit pulse samples, sent next frame
// - a-law or mu-law coding per variant
// - decoder updates 10 us after slot end
// - 256 kHz filter clock from master clock
// - receive output muted 10 ms after power-up
// - power-down 2 ms after last pulse
// - transmit output silent until second pulse
// - fixed select level selects transmit bit clock
// - 193rd master pulse absorbed each frame
package pcmsp_pkg;

  // pin positions in the synchroniser vector
  localparam int PIN_W    = 7;
  localparam int PIN_TXB  = 6;
  localparam int PIN_TXF  = 5;
  localparam int PIN_RXF  = 4;
  localparam int PIN_RSEL = 3;
  localparam int PIN_RXD  = 2;
  localparam int PIN_TXM  = 1;
  localparam int PIN_RPD  = 0;

  // code format
  localparam int         CODE_W   = 8;
  localparam logic [7:0] ALAW_INV = 8'h55;  // even bit inversion
  localparam logic [2:0] LAST_BIT = 3'h7;

  // timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int DECODE_TIME_NS = 10000;
  localparam int DECODE_CYC     = DECODE_TIME_NS / CLK_PERIOD_NS;
  localparam int MUTE_TIME_MS   = 10;
  localparam int MUTE_CYC       = MUTE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PDN_TIME_US    = 2000;
  localparam int PDN_CYC        = PDN_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int STATIC_TIME_NS = 20000;
  localparam int STATIC_CYC     = STATIC_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W          = 21;

  // master clock dividers down to 256 kHz, frame detection
  localparam logic [2:0] DIV_2048_LAST  = 3'h7;
  localparam logic [2:0] DIV_1536_LAST  = 3'h5;
  localparam logic [1:0] LONG_MIN_FALLS = 2'h2;
  localparam logic [1:0] TX_ALLOW_FRAME = 2'h2;
  localparam int         FIFO_DEPTH     = 32;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'h0,
    TX_ARM   = 2'h1,
    TX_SHIFT = 2'h3,
    TX_TAIL  = 2'h2
  } pcmsp_tx_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_SHIFT = 2'h1,
    RX_DEC   = 2'h3
  } pcmsp_rx_t;

endpackage : pcmsp_pkg

// ---- design/pcmsp_fifo.sv ----
module pcmsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire logic        push;
  wire logic        pop;

  // pointer compare, output stage loads when empty or drained
  assign in_ready_o = (wr_q - rd_q) != FULL;
  assign push       = in_valid_i & in_ready_o;
  assign pop        = (wr_q != rd_q) & (!out_valid_o | out_ready_i);

  // storage array
  always_ff @(posedge sys_clk_i) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data_i;
  end

  // pointers and registered output
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q        <= '0;
      rd_q        <= '0;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) begin
        rd_q       <= rd_q + 1'b1;
        out_data_o <= mem_q[rd_q[AW-1:0]];
      end
      if (pop) out_valid_o <= 1'b1;
      else if (out_ready_i) out_valid_o <= 1'b0;
    end
  end

endmodule : pcmsp_fifo

// ---- design/pcmsp_frame_port.sv ----
module pcmsp_frame_port
  import pcmsp_pkg::*;
#(
  parameter int LAW_A        = 1,         // 1: a-law variant, 0: mu-law variant
  parameter int MUTE_CYCLES  = MUTE_CYC,
  parameter int PDN_CYCLES   = PDN_CYC,
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  // highway pins
  input  wire logic              tx_bit_clock_i,
  input  wire logic              tx_frame_pulse_i,
  input  wire logic              rx_frame_pulse_i,
  input  wire logic              rx_bit_clock_or_rate_select_i,
  input  wire logic              rx_pcm_in_i,
  input  wire logic              tx_master_clock_i,
  input  wire logic              rx_master_clock_or_powerdown_i,
  output logic                   tx_pcm_out_o,
  output logic                   tx_pcm_out_oe_n_o,
  output logic                   tx_slot_indicator_o,
  output logic                   tx_slot_indicator_oe_n_o,
  // encoder side
  input  wire logic [CODE_W-1:0] tx_code_i,
  output logic                   tx_sample_o,
  // decoder side
  output logic [CODE_W-1:0]      rx_dac_code_o,
  output logic [CODE_W-1:0]      rx_code_o,
  output logic                   rx_code_valid_o,
  input  wire logic              rx_code_ready_i,
  output logic                   rx_overrun_o,
  // analog control
  output logic                   filter_clk_en_o,
  output logic                   rx_mute_o,
  output logic                   powered_up_o,
  output logic                   long_frame_o
);
  localparam logic [CNT_W-1:0] MUTE_LIM = CNT_W'(MUTE_CYCLES);
  localparam logic [CNT_W-1:0] PDN_LIM  = CNT_W'(PDN_CYCLES);
  localparam logic [CNT_W-1:0] STAT_LIM = CNT_W'(STATIC_CYC);
  localparam logic [CNT_W-1:0] DEC_LIM  = CNT_W'(DECODE_CYC - 1);

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  // saturating counter step
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lim);
    return (v >= lim) ? v : v + 1'b1;
  endfunction : sat_inc

  // companding bit map, used by both directions
  function automatic logic [CODE_W-1:0] law_map(input logic [CODE_W-1:0] c);
    return (LAW_A != 0) ? (c ^ ALAW_INV) : c;
  endfunction : law_map

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [PIN_W-1:0] sync1_q;
  logic [PIN_W-1:0] sync2_q;
  logic [PIN_W-1:0] prev_q;
  wire logic [PIN_W-1:0] pin_raw;
  wire logic [PIN_W-1:0] rise;
  wire logic [PIN_W-1:0] fall;

  assign pin_raw = {tx_bit_clock_i, tx_frame_pulse_i, rx_frame_pulse_i, rx_bit_clock_or_rate_select_i,
                    rx_pcm_in_i, tx_master_clock_i, rx_master_clock_or_powerdown_i};
  assign rise    = sync2_q & ~prev_q;
  assign fall    = ~sync2_q & prev_q;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // named pin events
  wire logic tx_rise  = rise[PIN_TXB];
  wire logic tx_fall  = fall[PIN_TXB];
  wire logic tx_frame_pulse      = sync2_q[PIN_TXF];
  wire logic fsx_rise = rise[PIN_TXF];
  wire logic fsx_fall = fall[PIN_TXF];
  wire logic rx_frame_pulse      = sync2_q[PIN_RXF];
  wire logic fsr_rise = rise[PIN_RXF];
  wire logic rx_din   = sync2_q[PIN_RXD];
  wire logic mck_rise = rise[PIN_TXM];

  ////////////////////////////////////////////////////////////////////////////
  // static level detection on the shared select and power-down pins
  logic [CNT_W-1:0] sel_st_q;
  logic [CNT_W-1:0] pd_st_q;
  wire logic        sync_mode;
  wire logic        pdn_pin;
  wire logic        sel_2048;

  assign sync_mode = sel_st_q >= STAT_LIM;                      // no edges: held level
  assign pdn_pin   = (pd_st_q >= STAT_LIM) & sync2_q[PIN_RPD];  // held high powers down
  assign sel_2048  = (LAW_A != 0) ? (!sync_mode | sync2_q[PIN_RSEL])
                                  : (sync_mode & !sync2_q[PIN_RSEL]);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_st_q <= '0;
      pd_st_q  <= '0;
    end else begin
      sel_st_q <= (rise[PIN_RSEL] | fall[PIN_RSEL]) ? '0 : sat_inc(sel_st_q, STAT_LIM);
      pd_st_q  <= (rise[PIN_RPD] | fall[PIN_RPD]) ? '0 : sat_inc(pd_st_q, STAT_LIM);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 256 kHz filter clock enable, realigned each frame
  logic [2:0] mck_cnt_q;
  logic       filt_en_q;
  wire logic [2:0] div_last = sel_2048 ? DIV_2048_LAST : DIV_1536_LAST;
  wire logic       div_wrap = mck_rise & (mck_cnt_q == div_last);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mck_cnt_q <= '0;
      filt_en_q <= 1'b0;
    end else begin
      if (fsx_rise) mck_cnt_q <= '0;
      else if (mck_rise) mck_cnt_q <= div_wrap ? 3'h0 : mck_cnt_q + 3'h1;
      filt_en_q <= div_wrap & !fsx_rise & powered_up_o;
    end
  end

  a_filter_single: assert property (filter_clk_en_o |=> !filter_clk_en_o) else $error("filter enable too long");
  a_frame_realign: assert property (fsx_rise |=> mck_cnt_q == 3'h0) else $error("divider not realigned");

  ////////////////////////////////////////////////////////////////////////////
  // power control and receive mute
  logic [CNT_W-1:0] idle_q;
  logic [CNT_W-1:0] mute_cnt_q;
  wire logic        fs_any  = fsx_rise | fsr_rise;
  wire logic        pu      = !powered_up_o & fs_any & !pdn_pin;
  wire logic        pwr_ok  = powered_up_o | pu;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_q       <= '0;
      mute_cnt_q   <= '0;
      powered_up_o <= 1'b0;
      rx_mute_o    <= 1'b1;
    end else begin
      idle_q <= fs_any ? '0 : sat_inc(idle_q, PDN_LIM);
      if (pdn_pin) powered_up_o <= 1'b0;
      else if (fs_any) powered_up_o <= 1'b1;
      else if (idle_q >= PDN_LIM) powered_up_o <= 1'b0;
      mute_cnt_q <= pu ? '0 : sat_inc(mute_cnt_q, MUTE_LIM);
      rx_mute_o  <= !powered_up_o | (mute_cnt_q < MUTE_LIM);
    end
  end

  a_mute_after_up: assert property ($rose(powered_up_o) |=> rx_mute_o [*8]) else $error("no mute at power-up");
  a_idle_power_down: assert property (powered_up_o && !pdn_pin && !fs_any && idle_q >= PDN_LIM
                                      |=> !powered_up_o) else $error("no power-down after idle");

  ////////////////////////////////////////////////////////////////////////////
  // frame mode detection from the transmit pulse width
  logic [1:0] width_q;
  logic [1:0] txf_cnt_q;
  wire logic  tx_allow = (txf_cnt_q == TX_ALLOW_FRAME) |
                         ((txf_cnt_q == TX_ALLOW_FRAME - 2'h1) & fsx_rise);

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      width_q      <= '0;
      long_frame_o <= 1'b0;
      txf_cnt_q    <= '0;
    end else begin
      if (!powered_up_o) begin
        width_q      <= '0;
        long_frame_o <= 1'b0;
      end else if (fsx_fall) begin
        long_frame_o <= width_q >= LONG_MIN_FALLS;
        width_q      <= '0;
      end else if (tx_frame_pulse && tx_fall && width_q != LONG_MIN_FALLS) begin
        width_q <= width_q + 2'h1;
      end
      if (!pwr_ok) txf_cnt_q <= '0;
      else if (fsx_rise && txf_cnt_q != TX_ALLOW_FRAME) txf_cnt_q <= txf_cnt_q + 2'h1;
    end
  end

  a_short_default: assert property (!powered_up_o |=> !long_frame_o) else $error("long mode while down");

  ////////////////////////////////////////////////////////////////////////////
  // transmit slot sequencer
  pcmsp_tx_t         tx_st_q;
  pcmsp_tx_t         tx_st_d;
  logic [2:0]        tx_cnt_q;
  logic [2:0]        tx_cnt_d;
  logic [CODE_W-1:0] tx_sr_q;
  logic [CODE_W-1:0] tx_sr_d;
  logic [CODE_W-1:0] tx_buf_q;
  logic              tx_dout_d;
  logic              tx_start;
  logic              tx_drive_q;
  logic              slot_lvl_q;
  wire logic short_start = !long_frame_o & tx_fall & tx_frame_pulse;
  wire logic long_start  = long_frame_o & tx_frame_pulse & ((fsx_rise & sync2_q[PIN_TXB]) | tx_rise);
  wire logic tx_drive_d  = tx_start ? tx_allow : tx_drive_q;
  wire logic tx_slot_d   = (tx_st_d == TX_SHIFT) | (tx_st_d == TX_TAIL);

  // next state: sign bit first, seven more on rising edges
  always_comb begin
    tx_st_d   = tx_st_q;
    tx_cnt_d  = tx_cnt_q;
    tx_sr_d   = tx_sr_q;
    tx_dout_d = tx_pcm_out_o;
    tx_start  = 1'b0;
    case (tx_st_q)
      TX_IDLE: begin
        if (pwr_ok && short_start) begin
          tx_st_d  = TX_ARM;
          tx_start = 1'b1;
          tx_sr_d  = tx_buf_q;
        end else if (pwr_ok && long_start) begin
          tx_st_d   = TX_SHIFT;
          tx_start  = 1'b1;
          tx_sr_d   = tx_buf_q;
          tx_dout_d = tx_buf_q[CODE_W-1];
          tx_cnt_d  = '0;
        end
      end
      TX_ARM: begin
        if (tx_rise) begin
          tx_st_d   = TX_SHIFT;
          tx_dout_d = tx_sr_q[CODE_W-1];
          tx_cnt_d  = '0;
        end
      end
      TX_SHIFT: begin
        if (tx_rise && tx_cnt_q != LAST_BIT) begin
          tx_sr_d   = {tx_sr_q[CODE_W-2:0], 1'b0};
          tx_dout_d = tx_sr_q[CODE_W-2];
          tx_cnt_d  = tx_cnt_q + 3'h1;
        end else if (tx_fall && tx_cnt_q == LAST_BIT) begin
          tx_st_d = (long_frame_o && tx_frame_pulse) ? TX_TAIL : TX_IDLE;
        end
      end
      TX_TAIL: begin
        if (!tx_frame_pulse) tx_st_d = TX_IDLE;
      end
      default: tx_st_d = TX_IDLE;
    endcase
    if (!powered_up_o && !pu) tx_st_d = TX_IDLE;
  end

  // slot registers; each start samples a new code for the next frame
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_st_q                  <= TX_IDLE;
      tx_cnt_q                 <= '0;
      tx_sr_q                  <= '0;
      tx_buf_q                 <= '0;
      tx_drive_q               <= 1'b0;
      tx_pcm_out_o             <= 1'b0;
      tx_pcm_out_oe_n_o        <= 1'b1;
      tx_slot_indicator_oe_n_o <= 1'b1;
      tx_sample_o              <= 1'b0;
      slot_lvl_q               <= 1'b0;
    end else begin
      tx_st_q                  <= tx_st_d;
      tx_cnt_q                 <= tx_cnt_d;
      tx_sr_q                  <= tx_sr_d;
      tx_drive_q               <= tx_drive_d;
      tx_pcm_out_o             <= tx_dout_d;
      tx_pcm_out_oe_n_o        <= !(tx_slot_d & tx_drive_d);
      tx_slot_indicator_oe_n_o <= !tx_slot_d;
      tx_sample_o              <= tx_start;
      slot_lvl_q               <= 1'b0;
      if (tx_start) tx_buf_q <= law_map(tx_code_i);
    end
  end
  assign tx_slot_indicator_o = slot_lvl_q;

  a_idle_released: assert property (tx_st_q == TX_IDLE |-> tx_pcm_out_oe_n_o) else $error("output driven in idle");
  a_short_enable: assert property (tx_st_q == TX_ARM && tx_rise && tx_drive_q && powered_up_o
                                   |=> !tx_pcm_out_oe_n_o && tx_pcm_out_o == $past(tx_sr_q[7])) else $error("no sign bit");
  a_long_enable: assert property (tx_st_q == TX_IDLE && powered_up_o && long_start && tx_allow
                                  |=> !tx_pcm_out_oe_n_o) else $error("long frame not enabled");
  a_short_release: assert property (tx_st_q == TX_SHIFT && tx_cnt_q == LAST_BIT && tx_fall && !long_frame_o
                                    |=> tx_pcm_out_oe_n_o) else $error("short slot not released");
  a_long_hold: assert property (tx_st_q == TX_TAIL && tx_frame_pulse && powered_up_o |=> !tx_slot_indicator_oe_n_o)
                 else $error("long slot released early");
  a_first_silent: assert property (tx_st_q != TX_IDLE && !tx_drive_q |-> tx_pcm_out_oe_n_o)
                    else $error("driven before second pulse");
  a_sample_taken: assert property (tx_sample_o |-> tx_buf_q == law_map($past(tx_code_i))) else $error("code not buffered");

  c_short_slot: cover property (tx_st_q == TX_ARM ##1 tx_st_q == TX_SHIFT);
  c_long_tail: cover property (tx_st_q == TX_TAIL ##1 tx_st_q == TX_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // receive slot sequencer with its own counter and decode timer
  pcmsp_rx_t         rx_st_q;
  pcmsp_rx_t         rx_st_d;
  logic [2:0]        rx_cnt_q;
  logic [2:0]        rx_cnt_d;
  logic [CODE_W-1:0] rx_sr_q;
  logic [CODE_W-1:0] rx_sr_d;
  logic [CNT_W-1:0]  dec_cnt_q;
  logic              rx_upd;
  wire logic         fifo_in_ready;
  wire logic rx_fall = sync_mode ? tx_fall : fall[PIN_RSEL];
  wire logic rx_arm  = long_frame_o ? fsr_rise : (rx_fall & rx_frame_pulse);

  // next state: eight captures, then wait out the decode time
  always_comb begin
    rx_st_d  = rx_st_q;
    rx_cnt_d = rx_cnt_q;
    rx_sr_d  = rx_sr_q;
    rx_upd   = 1'b0;
    case (rx_st_q)
      RX_IDLE: begin
        if (pwr_ok && rx_arm) begin
          rx_st_d  = RX_SHIFT;
          rx_cnt_d = '0;
        end
      end
      RX_SHIFT: begin
        if (rx_fall) begin
          rx_sr_d  = {rx_sr_q[CODE_W-2:0], rx_din};
          rx_cnt_d = rx_cnt_q + 3'h1;
          if (rx_cnt_q == LAST_BIT) rx_st_d = RX_DEC;
        end
      end
      RX_DEC: begin
        if (dec_cnt_q >= DEC_LIM && fifo_in_ready) begin
          rx_st_d = RX_IDLE;
          rx_upd  = 1'b1;
        end
      end
      default: rx_st_d = RX_IDLE;
    endcase
    if (!powered_up_o && !pu) rx_st_d = RX_IDLE;
  end

  // receive registers and decoder output
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_st_q       <= RX_IDLE;
      rx_cnt_q      <= '0;
      rx_sr_q       <= '0;
      dec_cnt_q     <= '0;
      rx_dac_code_o <= '0;
      rx_overrun_o  <= 1'b0;
    end else begin
      rx_st_q      <= rx_st_d;
      rx_cnt_q     <= rx_cnt_d;
      rx_sr_q      <= rx_sr_d;
      dec_cnt_q    <= (rx_st_q == RX_DEC) ? sat_inc(dec_cnt_q, DEC_LIM) : '0;
      rx_overrun_o <= (rx_st_q == RX_DEC) & rx_arm & powered_up_o;
      if (rx_upd) rx_dac_code_o <= law_map(rx_sr_q);
    end
  end

  // decoded codes queue toward the consumer; a full queue holds the decoder
  pcmsp_fifo #(
    .WIDTH (CODE_W),
    .DEPTH (FIFO_DEPTH_P)
  ) u_rx_fifo (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (rx_upd),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (law_map(rx_sr_q)),
    .out_valid_o (rx_code_valid_o),
    .out_ready_i (rx_code_ready_i),
    .out_data_o  (rx_code_o)
  );
  assign filter_clk_en_o = filt_en_q;

  a_rx_eight_bits: assert property (rx_st_q == RX_SHIFT && rx_fall && rx_cnt_q == LAST_BIT && powered_up_o
                                    |=> rx_st_q == RX_DEC) else $error("slot not closed after eight");
  a_sync_rx_clock: assert property (sync_mode && rx_st_q == RX_SHIFT && tx_fall && rx_cnt_q != LAST_BIT && powered_up_o
                                    |=> rx_cnt_q == $past(rx_cnt_q) + 3'h1) else $error("transmit clock unused");
  a_decode_delay: assert property ($rose(rx_st_q == RX_DEC) |-> !rx_upd [*8]) else $error("decoder updated early");
  a_dac_update: assert property (rx_upd |=> rx_dac_code_o == law_map($past(rx_sr_q))) else $error("decoder not updated");

  c_rx_decode: cover property (rx_upd ##1 rx_code_valid_o);
  c_power_down: cover property ($fell(powered_up_o));

endmodule : pcmsp_frame_port

// ---- testbench/pcmsp_highway.sv ----
module pcmsp_highway (
  // clocks and pulses toward the port
  output logic      bclk_o,
  output logic      frame_o,
  output logic      rxd_o,
  output logic      mclk_o,
  // serial data from the port
  input  wire logic txd_i,
  input  wire logic oe_n_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got;
  logic       drv_all;
  logic       drv_any;
  int         k;
  // master clock near 2.048 mhz, free running
  initial begin
    mclk_o = 1'b0;
    forever #244 mclk_o = ~mclk_o;
  end
  // bit clock stands low between frames
  initial begin
    bclk_o = 1'b0;
    frame_o = 1'b0;
    rxd_o = 1'b0;
  end
  // ten bit periods of 80 ns; data sent and taken eight of them
  task automatic frame(input logic lng, input logic [7:0] code);
    k = lng ? 0 : 1;
    drv_all = 1'b1;
    drv_any = 1'b0;
    #1; // keep pin edges off the system clock edge
    for (int i = 0; i < 10; i++) begin
      bclk_o = 1'b1;
      if (i == 0) frame_o = 1'b1;
      if (i >= k && i < k + 8) rxd_o = code[7-i+k];
      #40 bclk_o = 1'b0;
      if (i >= k && i < k + 8) begin
        got[7-i+k] = txd_i;
        drv_all &= ~oe_n_i;
        drv_any |= ~oe_n_i;
      end
      #20 if (i == (lng ? 2 : 0)) frame_o = 1'b0;
      #20;
    end
    rxd_o = ~rxd_o; // a released line shows no stale bit
  endtask : frame
endmodule : pcmsp_highway

// ---- testbench/pcmsp_frame_port_tb.sv ----
module pcmsp_frame_port_tb;
  import pcmsp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_n, bclk, fs, rxd, mclk, txd, oe_n, smp;
  logic       vld, rdy, ovr, flt, pwr, lng, mute;
  logic       mpd, slot_v, slot_n;
  logic [7:0] code, dac, rxc;
  logic [7:0] q[$];
  int         bad_count = 0;
  int         n_tests = 0;
  int         n_smp = 0;
  int         n_ovr = 0;
  int         n_flt = 0;
  int         n_slot = 0;
  pcmsp_highway i_pcmsp_highway (.bclk_o(bclk), .frame_o(fs), .rxd_o(rxd), .mclk_o(mclk),
                                 .txd_i(txd), .oe_n_i(oe_n));
  // select pin static high: synchronous mode on the transmit bit clock
  pcmsp_frame_port #(.LAW_A(1), .MUTE_CYCLES(200), .PDN_CYCLES(4000), .FIFO_DEPTH_P(2))
  i_pcmsp_frame_port (
    .sys_clk_i(clk), .reset_n_i(rst_n), .tx_bit_clock_i(bclk), .tx_frame_pulse_i(fs),
    .rx_frame_pulse_i(fs), .rx_bit_clock_or_rate_select_i(1'b1), .rx_pcm_in_i(rxd),
    .tx_master_clock_i(mclk), .rx_master_clock_or_powerdown_i(mpd), .tx_pcm_out_o(txd),
    .tx_pcm_out_oe_n_o(oe_n), .tx_slot_indicator_o(slot_v), .tx_slot_indicator_oe_n_o(slot_n),
    .tx_code_i(code), .tx_sample_o(smp), .rx_dac_code_o(dac), .rx_code_o(rxc),
    .rx_code_valid_o(vld), .rx_code_ready_i(rdy), .rx_overrun_o(ovr),
    .filter_clk_en_o(flt), .rx_mute_o(mute), .powered_up_o(pwr), .long_frame_o(lng));
  // 200 mhz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // pulse counters and the drain side of the buffer
  always @(posedge clk) begin
    if (smp === 1'b1) n_smp++;
    if (ovr === 1'b1) n_ovr++;
    if (flt === 1'b1) n_flt++;
    if (slot_n === 1'b0 && slot_v === 1'b0) n_slot++;
    if (vld === 1'b1 && rdy === 1'b1) q.push_back(rxc);
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one frame, then the slot must be released and the decoder given time
  task automatic go(input logic l, input logic [7:0] c);
    i_pcmsp_highway.frame(l, c);
    repeat (4) @(posedge clk);
    chk("oe_n", 8'h01, 8'(oe_n));
    repeat (2200) @(posedge clk);
  endtask : go
  task automatic t_short();
    @(posedge clk) code <= 8'ha7;
    go(1'b0, 8'h3c);
    chk("first drive", 8'h00, 8'(i_pcmsp_highway.drv_any));
    chk("slot low", 8'h01, 8'(n_slot inside {[119:121]}));
    chk("samples", 8'h01, 8'(n_smp));
    chk("mode", 8'h00, 8'(lng));
    @(posedge clk) code <= 8'h5a;
    go(1'b0, 8'hc3);
    chk("tx code", 8'ha7 ^ ALAW_INV, i_pcmsp_highway.got);
    chk("drive", 8'h01, 8'(i_pcmsp_highway.drv_all));
    chk("mute", 8'h00, 8'(mute));
    chk("dac", 8'hc3 ^ ALAW_INV, dac);
  endtask : t_short
  task automatic t_decode();
    i_pcmsp_highway.frame(1'b0, 8'h81);
    repeat (1900) @(posedge clk);
    chk("dac early", 8'hc3 ^ ALAW_INV, dac);
    repeat (300) @(posedge clk);
    chk("dac late", 8'h81 ^ ALAW_INV, dac);
  endtask : t_decode
  task automatic t_long();
    @(posedge clk) code <= 8'h0f;
    go(1'b1, 8'h96);
    chk("mode", 8'h01, 8'(lng));
    go(1'b1, 8'h42);
    chk("tx long", 8'h0f ^ ALAW_INV, i_pcmsp_highway.got);
    chk("dac long", 8'h42 ^ ALAW_INV, dac);
  endtask : t_long
  // consumer stalls: buffer and output stage hold three, a fourth waits, a fifth is refused
  task automatic t_fifo();
    logic [7:0] c [5];
    int         o0;
    c = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    o0 = n_ovr;
    @(posedge clk) rdy <= 1'b0;
    q.delete();
    for (int i = 0; i < 5; i++) go(1'b1, c[i]);
    chk("overrun", 8'h01, 8'(n_ovr - o0));
    chk("valid", 8'h01, 8'(vld));
    @(posedge clk) rdy <= 1'b1;
    repeat (2100) @(posedge clk);
    chk("words", 8'h04, 8'(q.size()));
    for (int i = 0; i < 4; i++) chk("fifo", c[i] ^ ALAW_INV, q[i]);
  endtask : t_fifo
  // filter enable rate, then power-down when frames stop
  task automatic t_pdn();
    int f0;
    i_pcmsp_highway.frame(1'b1, 8'h00);
    f0 = n_flt;
    repeat (3700) @(posedge clk);
    chk("powered", 8'h01, 8'(pwr));
    chk("filter", 8'h01, 8'((n_flt - f0) inside {[4:5]}));
    repeat (300) @(posedge clk);
    chk("powered", 8'h00, 8'(pwr));
    chk("mute", 8'h01, 8'(mute));
  endtask : t_pdn
  // power-down pin held high keeps the port down through a frame
  task automatic t_pin();
    @(posedge clk) mpd <= 1'b1;
    repeat (4100) @(posedge clk);
    i_pcmsp_highway.frame(1'b0, 8'h00);
    chk("pin held", 8'h00, 8'(pwr));
    @(posedge clk) mpd <= 1'b0;
    repeat (8) @(posedge clk);
    i_pcmsp_highway.frame(1'b0, 8'h00);
    chk("pin freed", 8'h01, 8'(pwr));
  endtask : t_pin
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // watchdog well beyond the expected run
  initial begin
    #400000;
    bad_count++;
    end_of_test();
  end
  // reset, then the scenarios in order
  initial begin
    rst_n = 1'b0;
    code = 8'h00;
    rdy = 1'b1;
    mpd = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("reset oe_n", 8'h01, 8'(oe_n));
    chk("reset mute", 8'h01, 8'(mute));
    chk("reset power", 8'h00, 8'(pwr));
    // the select pin must read static before synchronous receive works
    repeat (4100) @(posedge clk);
    t_short();
    t_decode();
    t_long();
    t_fifo();
    t_pdn();
    t_pin();
    end_of_test();
  end
endmodule : pcmsp_frame_port_tb
